/* File: core/spm_regs.svh */
// register offsets, field positions, reset values and counts of the serial master port
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// register offsets on the special function register port
`define SPM_ADDR_CKDIV 8'hA2
`define SPM_ADDR_DATA 8'hA3
`define SPM_ADDR_CTRL 8'hF8

// control register field positions
`define SPM_BIT_DONE 7
`define SPM_BIT_MASTER_ENABLE_FLAG 6
`define SPM_BIT_MODE_FAULT_FLAG 5
`define SPM_BIT_SELHI 3
`define SPM_BIT_SELLO 2
`define SPM_BIT_TXRDY 1
`define SPM_BIT_UEN 0

// reset values
`define SPM_CTRL_RST 8'h04
`define SPM_CKDIV_RST 8'h00
`define SPM_SEL_RST 2'h1

// select mode encodings
`define SPM_SEL_3WIRE 2'h0
`define SPM_SEL_MULTI 2'h1

// transfer geometry
`define SPM_WORD_W 8
`define SPM_TXBUF_DEPTH 8
`define SPM_LAST_BIT 3'h7

`endif

/* File: core/spm_pkg.sv */
// types shared by the serial master port modules
package spm_pkg;

typedef logic [7:0] spm_byte_t;

// gray order along idle -> shift -> idle
typedef enum logic [1:0] {
    SPM_ST_IDLE = 2'h0,
    SPM_ST_SHIFT = 2'h1
} spm_state_e;

typedef struct packed {
    spm_state_e state;
    logic master_en;
    logic unit_en;
    logic done;
    logic mode_fault_flag;
    logic [1:0] sel_mode;
    spm_byte_t ckdiv;
    spm_byte_t shreg;
    logic samp;
    logic [2:0] bitcnt;
    logic sck;
    logic mosi;
    spm_byte_t rxbuf;
    spm_byte_t rdata;
    logic miso_s1;
    logic miso_s2;
    logic nss_s1;
    logic nss_s2;
} spm_state_s;

endpackage

/* File: core/spm_fifo.sv */
// transmit byte buffer: flop storage with valid/ready on both sides
`timescale 1ns/1ns
module spm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } spm_fifo_st_s;

    spm_fifo_st_s q;
    spm_fifo_st_s d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] spm_wrap(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + AW'(1);
    endfunction

    assign in_ready = (q.count != (AW + 1)'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data = q.mem[q.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wptr] = in_data;
            d.wptr = spm_wrap(q.wptr);
        end
        if (pop) begin
            d.rptr = spm_wrap(q.rptr);
        end
        if (push && !pop) begin
            d.count = q.count + (AW + 1)'(1);
        end else if (pop && !push) begin
            d.count = q.count - (AW + 1)'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: core/spm_sck_gen.sv */
// half-period tick generator for the serial clock
`timescale 1ns/1ns
module spm_sck_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [7:0] div,
    // one pulse per half period of the serial clock
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
    } spm_gen_st_s;

    spm_gen_st_s q;
    spm_gen_st_s d;

    // half period lasts div+1 cycles, so a full period lasts 2*(div+1)
    assign tick = run && (q.cnt == div);

    always_comb begin
        d = q;
        if (!run || tick) begin
            // restart keeps the first half period of a byte full length
            d.cnt = 8'h00;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: core/spm_master_port.sv */
// serial peripheral master port with transmit buffer, receive buffer and select modes
//
// Functional notes
// - master operation only while master enable set
// - data writes land in transmit buffer
// - empty shifter takes buffered byte, starts transfer
// - started byte shifts out with generated clock
// - done flag set at end of byte
// - done flag raises enabled interrupt request
// - full duplex, one flag covers both directions
// - received bits enter shifter msb first
// - full byte goes to receive buffer, readable
// - multi-master default, select pin is input
// - low select clears enables, sets fault
// - mode fault raises enabled interrupt request
// - three-wire mode leaves select pin unused
// - four-wire mode drives select from low bit
// - clock rate is core over 2*(div+1)
// - divider steers the clock only as master
`timescale 1ns/1ns
`include "spm_regs.svh"
module spm_master_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire spm_pkg::spm_byte_t sfr_wdata,
    output spm_pkg::spm_byte_t sfr_rdata,
    // interrupt
    input wire logic irq_en,
    output logic irq_req,
    // transmit buffer back-pressure
    output logic tx_ready,
    // serial pins
    output logic sck_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic nss_i,
    output logic nss_o,
    output logic nss_oe
);
    import spm_pkg::*;

    spm_state_s q;
    spm_state_s d;

    logic wr_ctrl;
    logic wr_data;
    logic wr_ckdiv;
    logic tx_valid;
    logic tx_pop;
    spm_byte_t tx_byte;
    logic tick;
    logic fault;
    logic can_start;
    logic running;
    spm_byte_t rx_full;

    // address match used by both the write and the read path
    function automatic logic spm_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    // assemble the control register image from the current state
    function automatic spm_byte_t spm_ctrl_image(input spm_state_s s, input logic txrdy);
        spm_byte_t v;
        v = 8'h00;
        v[`SPM_BIT_DONE] = s.done;
        v[`SPM_BIT_MASTER_ENABLE_FLAG] = s.master_en;
        v[`SPM_BIT_MODE_FAULT_FLAG] = s.mode_fault_flag;
        v[`SPM_BIT_SELHI] = s.sel_mode[1];
        v[`SPM_BIT_SELLO] = s.sel_mode[0];
        v[`SPM_BIT_TXRDY] = txrdy;
        v[`SPM_BIT_UEN] = s.unit_en;
        return v;
    endfunction

    assign wr_ctrl = sfr_wr && spm_hit(sfr_addr, `SPM_ADDR_CTRL);
    assign wr_data = sfr_wr && spm_hit(sfr_addr, `SPM_ADDR_DATA);
    assign wr_ckdiv = sfr_wr && spm_hit(sfr_addr, `SPM_ADDR_CKDIV);

    assign fault = q.master_en && (q.sel_mode == `SPM_SEL_MULTI) && !q.nss_s2;

    // only an idle enabled master starts
    assign can_start = (q.state == SPM_ST_IDLE) && q.master_en && q.unit_en
        && tx_valid && !fault;
    assign tx_pop = can_start;

    // divider only runs while mastering a byte
    assign running = (q.state == SPM_ST_SHIFT) && q.master_en;

    // byte as it stands after the eighth sample is folded in
    assign rx_full = {q.shreg[6:0], q.samp};

    // data writes queue in the transmit buffer
    spm_fifo #(
        .WIDTH(`SPM_WORD_W),
        .DEPTH(`SPM_TXBUF_DEPTH)
    ) u_txbuf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(wr_data),
        .in_ready(tx_ready),
        .in_data(sfr_wdata),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_byte)
    );

    // half period of div+1 core cycles
    spm_sck_gen u_sck (
        .core_clk(core_clk),
        .rst(rst),
        .run(running),
        .div(q.ckdiv),
        .tick(tick)
    );

    always_comb begin
        d = q;

        // two-stage synchronisers for pins from outside
        d.miso_s1 = miso_i;
        d.miso_s2 = q.miso_s1;
        d.nss_s1 = nss_i;
        d.nss_s2 = q.nss_s1;

        // software writes to control; status flags only clear on a 0 write
        if (wr_ctrl) begin
            d.master_en = sfr_wdata[`SPM_BIT_MASTER_ENABLE_FLAG];
            d.unit_en = sfr_wdata[`SPM_BIT_UEN];
            d.sel_mode = {sfr_wdata[`SPM_BIT_SELHI], sfr_wdata[`SPM_BIT_SELLO]};
            d.done = q.done && sfr_wdata[`SPM_BIT_DONE];
            d.mode_fault_flag = q.mode_fault_flag && sfr_wdata[`SPM_BIT_MODE_FAULT_FLAG];
        end

        if (wr_ckdiv) begin
            d.ckdiv = sfr_wdata;
        end

        // load shifter and present msb at once
        if (can_start) begin
            d.state = SPM_ST_SHIFT;
            d.shreg = tx_byte;
            d.mosi = tx_byte[7];
            d.bitcnt = 3'h0;
            d.sck = 1'b0;
        end

        // low half ends with a sample on the rise, high half with a shift on the fall
        if (running && tick) begin
            if (!q.sck) begin
                d.sck = 1'b1;
                d.samp = q.miso_s2;
            end else begin
                d.sck = 1'b0;
                // received bit enters at the lsb end
                d.shreg = rx_full;
                d.mosi = q.shreg[6];
                d.bitcnt = q.bitcnt + 3'h1;
                if (q.bitcnt == `SPM_LAST_BIT) begin
                    // completed byte moves to receive buffer
                    d.rxbuf = rx_full;
                    // end of byte sets done flag
                    d.done = 1'b1;
                    d.state = SPM_ST_IDLE;
                end
            end
        end

        // fault drops both enables until rewritten
        if (fault) begin
            d.master_en = 1'b0;
            d.unit_en = 1'b0;
            d.mode_fault_flag = 1'b1;
        end

        // losing master enable abandons the byte in flight
        if (!d.master_en || !d.unit_en) begin
            d.state = SPM_ST_IDLE;
            d.sck = 1'b0;
        end

        // read data is latched so the bus sees a registered value
        if (sfr_rd) begin
            if (spm_hit(sfr_addr, `SPM_ADDR_CTRL)) begin
                d.rdata = spm_ctrl_image(q, tx_ready);
            end else if (spm_hit(sfr_addr, `SPM_ADDR_DATA)) begin
                // data reads return the receive buffer
                d.rdata = q.rxbuf;
            end else if (spm_hit(sfr_addr, `SPM_ADDR_CKDIV)) begin
                d.rdata = q.ckdiv;
            end else begin
                d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.sel_mode <= `SPM_SEL_RST;
            q.ckdiv <= `SPM_CKDIV_RST;
            q.nss_s1 <= 1'b1;
            q.nss_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata = q.rdata;
    assign sck_o = q.sck;
    assign mosi_o = q.mosi;

    // either flag requests service when enabled
    assign irq_req = irq_en && (q.done || q.mode_fault_flag);

    // four-wire drives select from the low mode bit
    assign nss_o = q.sel_mode[0];
    // three-wire and multi-master never drive it
    assign nss_oe = q.sel_mode[1];
endmodule

/* File: sim/spm_props.sv */
// concurrent checks on the serial master port pins
`timescale 1ns/1ns
module spm_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire spm_pkg::spm_byte_t sfr_wdata,
    input wire spm_pkg::spm_byte_t sfr_rdata,
    // interrupt and buffer
    input wire logic irq_en,
    input wire logic irq_req,
    input wire logic tx_ready,
    // serial pins
    input wire logic sck_o,
    input wire logic mosi_o,
    input wire logic miso_i,
    input wire logic nss_i,
    input wire logic nss_o,
    input wire logic nss_oe
);
    import spm_pkg::*;
    spm_byte_t div_r;
    spm_byte_t ctl_r;
    logic [8:0] hi_r;
    // shadows of software writes; hardware clears are not tracked
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_r <= 8'h00;
            ctl_r <= 8'h04;
            hi_r <= 9'h000;
        end else begin
            if (sfr_wr && sfr_addr == 8'hA2) begin
                div_r <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == 8'hF8) begin
                ctl_r <= sfr_wdata;
            end
            hi_r <= sck_o ? hi_r + 9'h001 : 9'h000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence sel_low_s;
        (ctl_r[6] && ctl_r[3:2] == 2'h1 && !nss_i && irq_en) [*4];
    endsequence
    sequence rd_div_s;
        sfr_rd && sfr_addr == 8'hA2;
    endsequence
    sck_high_a: assert property ($fell(sck_o) |-> hi_r == {1'b0, div_r} + 9'h001)
        else $error("serial clock high time wrong");
    mosi_edge_a: assert property ($changed(mosi_o) |-> !sck_o)
        else $error("data out moved while clock high");
    sel_drive_a: assert property (sfr_wr && sfr_addr == 8'hF8 |-> ##[1:2]
        (nss_oe == ctl_r[3] && (!ctl_r[3] || nss_o == ctl_r[2])))
        else $error("select pin drive wrong");
    fault_irq_a: assert property (sel_low_s |=> irq_req)
        else $error("select low gave no fault request");
    irq_gate_a: assert property (irq_req |-> irq_en)
        else $error("request while interrupts disabled");
    div_read_a: assert property (rd_div_s |=> sfr_rdata == div_r)
        else $error("divider read back wrong");
    unmapped_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($changed(sfr_rdata) |-> $past(sfr_rd))
        else $error("read data moved without read");
    master_only_a: assert property (!ctl_r[6] [*3] |-> !sck_o)
        else $error("serial clock without master enable");
endmodule
bind spm_master_port spm_props chk (.*);

/* File: sim/spm_slave.sv */
// far-side serial device: shifts a preset byte out, captures the master byte
`timescale 1ns/1ns
module spm_slave (
    // serial pins
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // preset and capture
    input wire logic [7:0] load_byte,
    input wire logic load,
    output logic [7:0] got
);
    logic [7:0] sh;
    always @(posedge sck) begin
        got <= {got[6:0], mosi};
    end
    // next bit on fall; spent bits refill with a toggling pattern
    always @(negedge sck or posedge load) begin
        if (load) begin
            sh <= load_byte;
        end else begin
            sh <= {sh[6:0], ~sh[0]};
        end
    end
    assign miso = sh[7];
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the serial master port
`timescale 1ns/1ns
module testbench;
    import spm_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    spm_byte_t sfr_wdata = 8'h00;
    spm_byte_t sfr_rdata;
    logic irq_en = 1'b0;
    logic nss_i = 1'b1;
    logic irq_req, tx_ready, sck_o, mosi_o, miso_i, nss_o, nss_oe;
    logic ld = 1'b0;
    spm_byte_t got;
    spm_byte_t v;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    spm_master_port uut (.*);
    spm_slave peer (.sck(sck_o), .mosi(mosi_o), .miso(miso_i), .load_byte(8'h3C),
        .load(ld), .got(got));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_done();
        logic [7:0] c;
        for (int i = 0; i < 300; i++) begin
            rd(8'hF8, c);
            if (c[7] === 1'b1) break;
        end
        chk("done", 8'h80, c & 8'h80);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'hF8, v);
        chk("ctrl", 8'h06, v);
        rd(8'h00, v);
        chk("unmapped", 8'h00, v);
        wr(8'hA2, 8'h03);
        rd(8'hA2, v);
        chk("ckdiv", 8'h03, v);
        $display("test registers done");
        ld <= 1'b1;
        wr(8'hF8, 8'h45);
        ld <= 1'b0;
        wr(8'hA3, 8'hA5);
        wait_done();
        rd(8'hA3, v);
        chk("rx", 8'h3C, v);
        chk("tx", 8'hA5, got);
        irq_en <= 1'b1;
        @(posedge core_clk);
        #1 chk("irq", 8'h01, {7'h0, irq_req});
        wr(8'hF8, 8'h45);
        chk("irq", 8'h00, {7'h0, irq_req});
        $display("test transfer done");
        // master off so the buffer only fills
        wr(8'hF8, 8'h05);
        for (int i = 0; i < 9; i++) wr(8'hA3, i[7:0]);
        rd(8'hF8, v);
        chk("full", 8'h05, v);
        wr(8'hF8, 8'h45);
        for (int i = 0; i < 8; i++) begin
            wait_done();
            wr(8'hF8, 8'h45);
        end
        chk("last", 8'h07, got);
        chk("ready", 8'h01, {7'h0, tx_ready});
        $display("test buffer done");
        nss_i <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(8'hF8, v);
        chk("fault", 8'h26, v);
        chk("irq", 8'h01, {7'h0, irq_req});
        nss_i <= 1'b1;
        wr(8'hF8, 8'h45);
        rd(8'hF8, v);
        chk("reenable", 8'h47, v);
        $display("test fault done");
        // three-wire master ignores a low select pin
        wr(8'hF8, 8'h41);
        nss_i <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(8'hF8, v);
        chk("threewire", 8'h43, v);
        chk("irq", 8'h00, {7'h0, irq_req});
        nss_i <= 1'b1;
        for (int i = 3; i >= 0; i--) begin
            wr(8'hF8, {4'h0, i[1:0], 2'h0});
            repeat (3) @(posedge core_clk);
            chk("sel", {6'h0, i[1:0]}, {6'h0, nss_oe, nss_o});
        end
        $display("test select done");
        end_of_test();
    end
endmodule
